/* File: irq_request_logic.sv */
// interrupt request, enable and pin logic with its AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none

// How it works
// - invert bit set drives the pin as the inverse of the combined status.
// - invert bit clear drives the pin equal to the combined status.
// - invert bit resets to 1, leaving the open-drain pin released.
// - primary enable bits 6..0 gate transmit..timer flags onto the pin.
// - secondary enable bit 7 picks push-pull (1) or open-drain (0).
// - secondary enable bit 4 gates ext input, bit 2 gates crc done.
// - request write sets marked bits if bit 7 is 1, else clears them.
// - transmit flag sets when the last transmitted bit has left.
// - receive flag sets at the end of a valid incoming stream.
// - with ignore-empty option, receive flag needs data in the fifo.
// - idle flag sets when the command field returns to idle.
// - an unknown command start sets the idle flag.
// - a host-written idle command does not set the idle flag.
// - high warning flag latches on the rising fifo high status.
// - low warning flag latches on the rising fifo low status.
// - error flag sets while any error status bit is set.
// - timer flag sets when the timer count reaches zero.
// - crc done flag sets when crc calculation has processed all data.
// - ext input flag sets on either edge of the modulation input.
module irq_request_logic
  import irq_regs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        tx_last_bit_sent,
  input  wire logic        rx_stream_end,
  input  wire logic        fifo_has_data,
  input  wire logic [3:0]  command_field,
  input  wire logic        host_idle_write,
  input  wire logic        unknown_cmd_start,
  input  wire logic        fifo_high_warning_status,
  input  wire logic        fifo_low_warning_status,
  input  wire logic [7:0]  error_status_register,
  input  wire logic [15:0] timer_count_register,
  input  wire logic        crc_calc_active,
  input  wire logic        crc_all_processed,
  input  wire logic        external_modulation_input,
  output logic             irq_pin_o,
  output logic             irq_pin_oe
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [5:0]  wr_idx;
    logic [7:0]  wr_data;
    logic        wr_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  en_pri;
    logic [7:0]  en_sec;
    logic [7:0]  req_pri;
    logic [7:0]  req_sec;
    logic        ignore_empty;
    logic [3:0]  cmd_prev;
    logic        hi_prev;
    logic        lo_prev;
    logic        tmr_zero_prev;
    logic        ext_prev;
    logic        irq_level;
    logic        irq_o;
    logic        irq_oe;
  } state_t;

  state_t     s_r;
  state_t     s_nxt;
  logic       aw_hs;
  logic       w_hs;
  logic       do_wr;
  logic [7:0] ev_pri;
  logic [7:0] ev_sec;
  logic [7:0] rd_val;
  logic       pin_val;
  logic [7:0] gated_pri;
  logic [7:0] gated_sec;
  logic       tmr_zero;

  // ****************************************************************
  // value after reset: bus slots open, pin released
  // ****************************************************************
  localparam state_t S_RESET = '{
    aw_got:        1'b0,
    w_got:         1'b0,
    wr_idx:        6'h00,
    wr_data:       8'h00,
    wr_strb:       1'b0,
    awready:       1'b1,
    wready:        1'b1,
    bvalid:        1'b0,
    bresp:         RESP_OKAY,
    arready:       1'b1,
    rvalid:        1'b0,
    rdata:         32'h0000_0000,
    rresp:         RESP_OKAY,
    en_pri:        RST_EN_PRI,
    en_sec:        RST_EN_SEC,
    req_pri:       RST_REQ_PRI,
    req_sec:       RST_REQ_SEC,
    ignore_empty:  1'b0,
    cmd_prev:      CMD_IDLE,
    hi_prev:       1'b0,
    lo_prev:       1'b0,
    tmr_zero_prev: 1'b1,
    ext_prev:      1'b0,
    irq_level:     1'b0,
    irq_o:         1'b0,
    irq_oe:        1'b0
  };

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic reg_known(input logic [5:0] idx);
    reg_known = (idx == IDX_EN_PRI) || (idx == IDX_EN_SEC) ||
                (idx == IDX_REQ_PRI) || (idx == IDX_REQ_SEC) ||
                (idx == IDX_STATE) || (idx == IDX_OPTION);
  endfunction

  // set wins over clear because hardware events are ORed in afterwards
  function automatic logic [7:0] set_clr(input logic [7:0] old,
                                         input logic [7:0] wd,
                                         input logic [7:0] mask);
    logic [7:0] marked;
    marked = wd & mask;
    if (wd[BIT_SET_CLEAR]) begin
      set_clr = old | marked;
    end else begin
      set_clr = old & ~marked;
    end
  endfunction

  // rising edge of a level against its value one clock earlier
  function automatic logic rose(input logic now_v,
                                input logic was_v);
    rose = now_v & ~was_v;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_nxt   = s_r;
    aw_hs   = awvalid & s_r.awready;
    w_hs    = wvalid & s_r.wready;
    do_wr   = 1'b0;
    ev_pri  = 8'h00;
    ev_sec  = 8'h00;
    rd_val  = 8'h00;
    pin_val = 1'b0;
    tmr_zero = (timer_count_register == 16'h0000);

    // write channel: address and data in either order
    if (aw_hs) begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.awready = 1'b0;
      s_nxt.wr_idx  = awaddr[7:2];
    end
    if (w_hs) begin
      s_nxt.w_got   = 1'b1;
      s_nxt.wready  = 1'b0;
      s_nxt.wr_data = wdata[7:0];
      s_nxt.wr_strb = wstrb[0];
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end
    // lands once both halves are in and the previous answer has gone
    do_wr = s_nxt.aw_got & s_nxt.w_got & ~s_r.bvalid;
    if (do_wr) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = reg_known(s_nxt.wr_idx) ? RESP_OKAY : RESP_DECERR;
      // only lane 0 carries register bits; other lanes are ignored
      if (s_nxt.wr_strb) begin
        case (s_nxt.wr_idx)
          IDX_EN_PRI: begin
            s_nxt.en_pri = s_nxt.wr_data;
          end
          IDX_EN_SEC: begin
            // reserved bits are not stored, so they read back as zero
            s_nxt.en_sec = s_nxt.wr_data & MASK_EN_SEC;
          end
          IDX_REQ_PRI: begin
            s_nxt.req_pri = set_clr(s_r.req_pri, s_nxt.wr_data, MASK_PRI);
          end
          IDX_REQ_SEC: begin
            s_nxt.req_sec = set_clr(s_r.req_sec, s_nxt.wr_data, MASK_SEC);
          end
          IDX_OPTION: begin
            s_nxt.ignore_empty = s_nxt.wr_data[0];
          end
          default: begin
          end
        endcase
      end
    end

    // read channel
    // read data show the state before the events of the same edge
    case (araddr[7:2])
      IDX_EN_PRI: begin
        rd_val = s_r.en_pri;
      end
      IDX_EN_SEC: begin
        rd_val = s_r.en_sec;
      end
      IDX_REQ_PRI: begin
        rd_val = s_r.req_pri;
      end
      IDX_REQ_SEC: begin
        rd_val = s_r.req_sec;
      end
      IDX_STATE: begin
        rd_val = {6'h00, s_r.irq_o, s_r.irq_level};
      end
      IDX_OPTION: begin
        rd_val = {7'h00, s_r.ignore_empty};
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end
    if (arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rdata   = {24'h00_0000, rd_val};
      s_nxt.rresp   = reg_known(araddr[7:2]) ? RESP_OKAY : RESP_DECERR;
    end

    // ****************************************************************
    // hardware events; flags are sticky until the host clears them
    // ****************************************************************
    ev_pri[BIT_TX] = tx_last_bit_sent;
    ev_pri[BIT_RX] = rx_stream_end &
                     (~s_r.ignore_empty | fifo_has_data);
    ev_pri[BIT_IDLE] = unknown_cmd_start |
                       ((s_r.cmd_prev != CMD_IDLE) &&
                        (command_field == CMD_IDLE) &&
                        !host_idle_write);
    ev_pri[BIT_HI] = rose(fifo_high_warning_status, s_r.hi_prev);
    ev_pri[BIT_LO] = rose(fifo_low_warning_status, s_r.lo_prev);
    // error is a level: a standing error keeps setting the flag again
    ev_pri[BIT_ERR] = |error_status_register;
    // only the step onto zero counts, not a counter resting at zero
    ev_pri[BIT_TMR] = rose(tmr_zero, s_r.tmr_zero_prev);
    ev_sec[BIT_CRC] = crc_calc_active & crc_all_processed;
    // the stored level resets low, so a high input at release counts once
    ev_sec[BIT_EXT] = external_modulation_input ^ s_r.ext_prev;

    // no hardware path clears a flag; only the set/clear write does
    s_nxt.req_pri = s_nxt.req_pri | ev_pri;
    s_nxt.req_sec = s_nxt.req_sec | ev_sec;

    s_nxt.cmd_prev      = command_field;
    s_nxt.hi_prev       = fifo_high_warning_status;
    s_nxt.lo_prev       = fifo_low_warning_status;
    s_nxt.tmr_zero_prev = tmr_zero;
    s_nxt.ext_prev      = external_modulation_input;

    // ****************************************************************
    // combined status and pin drive
    // ****************************************************************
    // each flag reaches the pin only through its own enable bit
    gated_pri       = s_nxt.req_pri & s_nxt.en_pri & MASK_PRI;
    gated_sec       = s_nxt.req_sec & s_nxt.en_sec & MASK_SEC;
    s_nxt.irq_level = (|gated_pri) | (|gated_sec);
    if (s_nxt.en_pri[BIT_INVERT]) begin
      pin_val = ~s_nxt.irq_level;
    end else begin
      pin_val = s_nxt.irq_level;
    end
    // open drain only pulls low, so a high level releases the pin
    if (s_nxt.en_sec[BIT_PUSH_PULL]) begin
      s_nxt.irq_o  = pin_val;
      s_nxt.irq_oe = 1'b1;
    end else begin
      s_nxt.irq_o  = 1'b0;
      s_nxt.irq_oe = ~pin_val;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= S_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready    = s_r.awready;
  assign wready     = s_r.wready;
  assign bvalid     = s_r.bvalid;
  assign bresp      = s_r.bresp;
  assign arready    = s_r.arready;
  assign rvalid     = s_r.rvalid;
  assign rdata      = s_r.rdata;
  assign rresp      = s_r.rresp;
  assign irq_pin_o  = s_r.irq_o;
  assign irq_pin_oe = s_r.irq_oe;

endmodule
`default_nettype wire

/* File: irq_regs_pkg.sv */
// register map, field positions and reset values of the interrupt block
`default_nettype none
package irq_regs_pkg;

  // ****************************************************************
  // register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [5:0] IDX_EN_PRI  = 6'h02;
  localparam logic [5:0] IDX_EN_SEC  = 6'h03;
  localparam logic [5:0] IDX_REQ_PRI = 6'h04;
  localparam logic [5:0] IDX_REQ_SEC = 6'h05;
  localparam logic [5:0] IDX_STATE   = 6'h08;
  localparam logic [5:0] IDX_OPTION  = 6'h09;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_SET_CLEAR = 7;
  localparam int BIT_INVERT    = 7;
  localparam int BIT_PUSH_PULL = 7;
  localparam int BIT_TX        = 6;
  localparam int BIT_RX        = 5;
  localparam int BIT_IDLE      = 4;
  localparam int BIT_HI        = 3;
  localparam int BIT_LO        = 2;
  localparam int BIT_ERR       = 1;
  localparam int BIT_TMR       = 0;
  localparam int BIT_EXT       = 4;
  localparam int BIT_CRC       = 2;

  // ****************************************************************
  // masks and values after reset
  // ****************************************************************
  localparam logic [7:0] MASK_PRI    = 8'h7f;
  localparam logic [7:0] MASK_EN_SEC = 8'h94;
  localparam logic [7:0] MASK_SEC    = 8'h14;
  localparam logic [7:0] RST_EN_PRI  = 8'h80;
  localparam logic [7:0] RST_EN_SEC  = 8'h00;
  localparam logic [7:0] RST_REQ_PRI = 8'h14;
  localparam logic [7:0] RST_REQ_SEC = 8'h00;
  localparam logic [3:0] CMD_IDLE    = 4'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage
`default_nettype wire

/* File: irq_request_logic_asserts.sv */
// port assertions for the interrupt request block
`timescale 1ns/100ps
`default_nettype none
module irq_request_logic_asserts
  import irq_regs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        irq_pin_o,
  input wire logic        irq_pin_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ****************
  // bus and pin
  // ****************
  wr_answer_a: assert property (
    awvalid && awready && wvalid && wready |=> bvalid)
    else $error("no write response");
  wr_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  wr_busy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write slot open too early");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("no read data");
  rd_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  rd_busy_a: assert property (rvalid |-> !arready)
    else $error("read slot open too early");
  upper_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  unmapped_read_a: assert property (
    arvalid && arready && araddr == 8'hfc
    |=> rresp == RESP_DECERR && rdata == 32'h0000_0000)
    else $error("unmapped read answered");
  drive_mode_a: assert property (irq_pin_o |-> irq_pin_oe)
    else $error("pin high but not driven");
endmodule
bind irq_request_logic irq_request_logic_asserts chk (
  .ref_clk    (ref_clk),
  .sys_rst    (sys_rst),
  .awvalid    (awvalid),
  .awready    (awready),
  .wvalid     (wvalid),
  .wready     (wready),
  .bresp      (bresp),
  .bvalid     (bvalid),
  .bready     (bready),
  .araddr     (araddr),
  .arvalid    (arvalid),
  .arready    (arready),
  .rdata      (rdata),
  .rresp      (rresp),
  .rvalid     (rvalid),
  .rready     (rready),
  .irq_pin_o  (irq_pin_o),
  .irq_pin_oe (irq_pin_oe)
);
`default_nettype wire

/* File: irq_host_pin.sv */
// host side of the interrupt pin, with its pull-up
`timescale 1ns/100ps
`default_nettype none
module irq_host_pin (
  input  wire logic irq_pin_o,
  input  wire logic irq_pin_oe,
  output logic      pin_level
);
  // a released open-drain pin is pulled high by the host board
  assign pin_level = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule
`default_nettype wire

/* File: reader_interrupt_request_logic_tb_top.sv */
// self-checking bench of the interrupt request block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, x) begin checks++; if ((a) !== (x)) begin n_mismatch++; \
  $display("wrong value at %0t: %h vs %h", $time, a, x); end end
module reader_interrupt_request_logic_tb_top;
  import irq_regs_pkg::*;
  logic        ref_clk = 1'b0, sys_rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, d;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'hf, command_field = 4'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq_pin_o;
  logic        irq_pin_oe, pin_level;
  logic [1:0]  bresp, rresp, eb;
  logic        tx_last_bit_sent = 0, rx_stream_end = 0, fifo_has_data = 0;
  logic        host_idle_write = 0, unknown_cmd_start = 0;
  logic        fifo_high_warning_status = 0, fifo_low_warning_status = 0;
  logic [7:0]  error_status_register = 8'h00;
  logic [15:0] timer_count_register = 16'h0000;
  logic        crc_calc_active = 0, crc_all_processed = 0;
  logic        external_modulation_input = 0;
  logic [33:0] e, expq[$];
  logic [1:0]  bq[$];
  logic [7:0]  ev_exp[9] = '{8'h40, 8'h20, 8'h10, 8'h10, 8'h08, 8'h04,
                             8'h02, 8'h01, 8'h00};
  int          n_mismatch = 0, checks = 0, seed;

  irq_request_logic dut (
    .ref_clk                   (ref_clk),
    .sys_rst                   (sys_rst),
    .awaddr                    (awaddr),
    .awvalid                   (awvalid),
    .awready                   (awready),
    .wdata                     (wdata),
    .wstrb                     (wstrb),
    .wvalid                    (wvalid),
    .wready                    (wready),
    .bresp                     (bresp),
    .bvalid                    (bvalid),
    .bready                    (bready),
    .araddr                    (araddr),
    .arvalid                   (arvalid),
    .arready                   (arready),
    .rdata                     (rdata),
    .rresp                     (rresp),
    .rvalid                    (rvalid),
    .rready                    (rready),
    .tx_last_bit_sent          (tx_last_bit_sent),
    .rx_stream_end             (rx_stream_end),
    .fifo_has_data             (fifo_has_data),
    .command_field             (command_field),
    .host_idle_write           (host_idle_write),
    .unknown_cmd_start         (unknown_cmd_start),
    .fifo_high_warning_status  (fifo_high_warning_status),
    .fifo_low_warning_status   (fifo_low_warning_status),
    .error_status_register     (error_status_register),
    .timer_count_register      (timer_count_register),
    .crc_calc_active           (crc_calc_active),
    .crc_all_processed         (crc_all_processed),
    .external_modulation_input (external_modulation_input),
    .irq_pin_o                 (irq_pin_o),
    .irq_pin_oe                (irq_pin_oe)
  );
  irq_host_pin host (.irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
                     .pin_level(pin_level));
  always #2.5 ref_clk = ~ref_clk;

  // ****************
  // bus tasks and result watcher
  // ****************
  task automatic wr(input logic [7:0] a, v, input logic [1:0] r);
    @(posedge ref_clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge ref_clk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge ref_clk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge ref_clk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, v, input logic [1:0] r);
    @(posedge ref_clk);
    expq.push_back({r, 24'h00_0000, v});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    rready <= 1'b0;
  endtask
  always @(posedge ref_clk) begin
    if (rvalid && rready) begin
      e = expq.pop_front();
      `CHK({rresp, rdata}, e)
    end
    if (bvalid && bready) begin
      eb = bq.pop_front();
      `CHK(bresp, eb)
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #200_000;
    n_mismatch++;
    print_verdict();
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    seed = $urandom(64);
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'h08, 8'h80, RESP_OKAY);
    `CHK(irq_pin_oe, 1'b0)
    rd(8'h0c, 8'h00, RESP_OKAY);
    rd(8'h10, 8'h14, RESP_OKAY);
    rd(8'hfc, 8'h00, RESP_DECERR);
    wr(8'hfc, 8'h55, RESP_DECERR);
    wr(8'h10, 8'h14, RESP_OKAY);
    rd(8'h10, 8'h00, RESP_OKAY);
    wr(8'h10, 8'h83, RESP_OKAY);
    wr(8'h10, 8'h01, RESP_OKAY);
    rd(8'h10, 8'h02, RESP_OKAY);
    wr(8'h10, 8'h7f, RESP_OKAY);
    repeat (4) begin
      d = 8'($urandom);
      wr(8'h08, d, RESP_OKAY);
      rd(8'h08, d, RESP_OKAY);
      wr(8'h0c, d, RESP_OKAY);
      rd(8'h0c, d & 8'h94, RESP_OKAY);
    end
    wr(8'h08, 8'h80, RESP_OKAY);
    // a write with lane 0 disabled is answered but changes nothing
    wstrb <= 4'h0;
    wr(8'h08, 8'h3f, RESP_OKAY);
    wstrb <= 4'hf;
    rd(8'h08, 8'h80, RESP_OKAY);
    for (int k = 0; k < 9; k++) begin
      @(posedge ref_clk);
      command_field <= (k == 2 || k == 8) ? 4'h5 : 4'h0;
      timer_count_register <= (k == 7) ? 16'h0005 : 16'h0000;
      @(posedge ref_clk);
      case (k)
        0: tx_last_bit_sent <= 1'b1;
        1: rx_stream_end <= 1'b1;
        2: command_field <= 4'h0;
        3: unknown_cmd_start <= 1'b1;
        4: fifo_high_warning_status <= 1'b1;
        5: fifo_low_warning_status <= 1'b1;
        6: error_status_register <= 8'h41;
        7: timer_count_register <= 16'h0000;
        default: begin
          command_field <= 4'h0;
          host_idle_write <= 1'b1;
        end
      endcase
      @(posedge ref_clk);
      {tx_last_bit_sent, rx_stream_end, unknown_cmd_start} <= 3'h0;
      {fifo_high_warning_status, fifo_low_warning_status} <= 2'h0;
      error_status_register <= 8'h00;
      host_idle_write <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(8'h10, ev_exp[k], RESP_OKAY);
      wr(8'h10, 8'h7f, RESP_OKAY);
    end
    wr(8'h24, 8'h01, RESP_OKAY);
    for (int j = 0; j < 2; j++) begin
      @(posedge ref_clk);
      fifo_has_data <= j[0];
      rx_stream_end <= 1'b1;
      @(posedge ref_clk);
      rx_stream_end <= 1'b0;
      rd(8'h10, j ? 8'h20 : 8'h00, RESP_OKAY);
    end
    wr(8'h10, 8'h7f, RESP_OKAY);
    @(posedge ref_clk);
    {crc_calc_active, crc_all_processed} <= 2'h3;
    external_modulation_input <= 1'b1;
    @(posedge ref_clk);
    {crc_calc_active, crc_all_processed} <= 2'h0;
    rd(8'h14, 8'h14, RESP_OKAY);
    wr(8'h14, 8'h14, RESP_OKAY);
    // falling edge counts too; crc done needs the calculation active as well
    @(posedge ref_clk);
    {crc_calc_active, crc_all_processed} <= 2'h1;
    external_modulation_input <= 1'b0;
    @(posedge ref_clk);
    crc_all_processed <= 1'b0;
    rd(8'h14, 8'h10, RESP_OKAY);
    wr(8'h14, 8'h14, RESP_OKAY);
    // an event in the cycle of a clearing write keeps its flag
    fork
      wr(8'h10, 8'h40, RESP_OKAY);
      begin
        @(posedge ref_clk);
        tx_last_bit_sent <= 1'b1;
        @(posedge ref_clk);
        tx_last_bit_sent <= 1'b0;
      end
    join
    rd(8'h10, 8'h40, RESP_OKAY);
    wr(8'h10, 8'hc0, RESP_OKAY);
    // every polarity and drive mode with the transmit source pending
    for (int m = 0; m < 4; m++) begin
      wr(8'h0c, {m[1], 7'h00}, RESP_OKAY);
      wr(8'h08, {m[0], 7'h40}, RESP_OKAY);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(pin_level, !m[0])
      `CHK(irq_pin_oe, m[1] | m[0])
      rd(8'h20, {6'h00, m[1] & ~m[0], 1'b1}, RESP_OKAY);
      wr(8'h08, {m[0], 7'h3f}, RESP_OKAY);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(pin_level, m[0])
    end
    // reset in mid-run restores the registers and releases the pin
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'h10, 8'h14, RESP_OKAY);
    rd(8'h08, 8'h80, RESP_OKAY);
    `CHK(pin_level, 1'b1)
    `CHK(irq_pin_oe, 1'b0)
    print_verdict();
  end
endmodule
`default_nettype wire
